// ### mch_params.svh
`ifndef MCH_PARAMS_SVH
`define MCH_PARAMS_SVH
`define MCH_CLK_HZ 20000000
`define MCH_RESET_DELAY_MS 100
`define MCH_RESET_DELAY_CYCLES (`MCH_RESET_DELAY_MS * (`MCH_CLK_HZ / 1000))
`define MCH_FT_LOCAL_AT 8'h08
`define MCH_FT_QUEUED_AT 8'h09
`define MCH_FT_REMOTE_AT 8'h17
`define MCH_FT_RX_PLAIN 8'h90
`define MCH_FT_RX_EXPLICIT 8'h91
`define MCH_REMOTE_APPLY_BIT 1
`define MCH_FW_VERSION 16'h1000
// arbitrary hardware version value
`define MCH_HW_VERSION 16'h0007
`define MCH_HW_COMPAT_RST 16'h0001
`define MCH_NPARAM 8
`define MCH_P_BAUD 3'h0
`define MCH_P_STACK 3'h1
`define MCH_P_COMPAT 3'h2
`define MCH_P_KEY 3'h3
`define MCH_P_AO 3'h4
`define MCH_FACTORY_BAUD 16'h0003
`define MCH_FACTORY_OTHER 16'h0000
`define MCH_REG_STATUS 4'h0
`define MCH_REG_HWCOMPAT 4'h1
`define MCH_REG_SENSOR 4'h2
`define MCH_REG_BAUD 4'h3
`define MCH_ST_CMDMODE 0
`define MCH_ST_RSTPEND 1
`define MCH_ST_BOOTBLK 2
`define MCH_ST_CUSTNEXT 3
`define MCH_ST_NVBUSY 4
`define MCH_ST_PENDING 5
`endif

// ### mch_pkg.sv
package mch_pkg;
   typedef enum logic [4:0] {
      MCH_C_TEMP = 5'h00, MCH_C_SUPPLY = 5'h01, MCH_C_POWER = 5'h02,
      MCH_C_FWVER = 5'h03, MCH_C_HWVER = 5'h04, MCH_C_COMPAT = 5'h05,
      MCH_C_RESTART = 5'h06, MCH_C_APPLY = 5'h07, MCH_C_WRITE = 5'h08,
      MCH_C_RESTORE = 5'h09, MCH_C_SETCUST = 5'h0a,
      MCH_C_CLRCUST = 5'h0b, MCH_C_FACTORY = 5'h0c,
      MCH_C_BOOTLDR = 5'h0d, MCH_C_EXIT = 5'h0e, MCH_C_PARAM = 5'h0f
   } mch_cmd_t;
   typedef enum logic [2:0] {
      MCH_S_IDLE = 3'b001, MCH_S_NVWAIT = 3'b010, MCH_S_RSTWAIT = 3'b100
   } mch_state_t;
   typedef enum logic [1:0] {
      MCH_R_OK = 2'h0, MCH_R_ERROR = 2'h1, MCH_R_VALUE = 2'h2
   } mch_resp_t;
endpackage

// ### mch_command_handler.sv
`timescale 1ns/1ps
`default_nettype none
`include "mch_params.svh"
module mch_command_handler #(
   parameter int unsigned RESET_DELAY_CYCLES = `MCH_RESET_DELAY_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   // decoded command from the parser
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire mch_pkg::mch_cmd_t cmd_code,
   input wire logic cmd_api,
   input wire logic [7:0] cmd_frame_type,
   input wire logic [7:0] cmd_frame_id,
   input wire logic [7:0] cmd_options,
   input wire logic cmd_is_set,
   input wire logic [2:0] cmd_param_sel,
   input wire logic [15:0] cmd_value,
   input wire logic cmd_mode_enter,
   input wire logic cmd_mode_timeout,
   // response
   output logic resp_valid,
   output mch_pkg::mch_resp_t resp_status,
   output logic [15:0] resp_value,
   output logic [7:0] resp_frame_id,
   output logic [7:0] resp_frame_type,
   // flash
   output logic nv_write_start,
   input wire logic nv_done,
   // reset and boot
   output logic sys_reset_req,
   output logic boot_to_loader,
   output logic boot_enable,
   input wire logic fw_load_valid,
   input wire logic [15:0] fw_compat_num,
   input wire logic fw_image_bad,
   output logic fw_load_accept,
   output logic fw_load_reject,
   // sensors and straps
   input wire logic [15:0] temp_c,
   input wire logic [15:0] supply_mv,
   input wire logic power_variant_pin,
   // operating settings
   output logic [15:0] baud_rate_setting,
   output logic cmd_mode,
   // transmit status
   input wire logic tx_req_valid,
   input wire logic [7:0] tx_req_frame_id,
   input wire logic tx_done,
   input wire logic [7:0] tx_cause,
   output logic txs_valid,
   output logic [7:0] txs_frame_id,
   output logic [7:0] txs_cause,
   // received data and remote responses
   input wire logic rx_valid,
   output logic rx_out_valid,
   output logic [7:0] rx_out_type,
   input wire logic remote_resp_valid,
   input wire logic remote_delivered,
   input wire logic [7:0] remote_resp_id,
   output logic remote_resp_out_valid,
   output logic [7:0] remote_resp_out_id,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   import mch_pkg::*;

   mch_state_t state;
   mch_state_t next_state;
   logic [21:0] rst_cnt;
   logic rst_to_loader;
   logic custom_next;
   logic boot_block;
   logic [15:0] hw_compat;
   logic power_meta;
   logic power_sync;
   logic [15:0] active [`MCH_NPARAM];
   logic [15:0] pending [`MCH_NPARAM];
   logic [15:0] custom [`MCH_NPARAM];
   logic [`MCH_NPARAM-1:0] pend_mask;
   logic [`MCH_NPARAM-1:0] cust_mask;
   logic [7:0] nv_frame_id;
   logic [7:0] nv_frame_type;
   logic nv_api;
   logic [7:0] tx_id_hold;
   logic tx_busy;

   wire take = cmd_valid && cmd_ready;
   wire is_remote = cmd_api && (cmd_frame_type == `MCH_FT_REMOTE_AT);
   wire is_query = (cmd_code == MCH_C_TEMP) || (cmd_code == MCH_C_SUPPLY)
      || (cmd_code == MCH_C_POWER) || (cmd_code == MCH_C_FWVER)
      || (cmd_code == MCH_C_HWVER) || (cmd_code == MCH_C_COMPAT);
   wire is_custom_cmd = (cmd_code == MCH_C_SETCUST)
      || (cmd_code == MCH_C_CLRCUST);
   wire refused = (is_query && cmd_is_set)
      || (is_remote && is_custom_cmd)
      || (is_remote && (cmd_code == MCH_C_BOOTLDR));
   wire go = take && !refused;
   wire do_param = go && (cmd_code == MCH_C_PARAM) && cmd_is_set;
   wire do_restore = go && (cmd_code == MCH_C_RESTORE);
   wire do_factory = go && (cmd_code == MCH_C_FACTORY);
   wire do_clrcust = go && (cmd_code == MCH_C_CLRCUST);
   wire do_write = go && (cmd_code == MCH_C_WRITE);
   wire do_restart = go && (cmd_code == MCH_C_RESTART);
   wire do_bootldr = go && (cmd_code == MCH_C_BOOTLDR);
   wire frame_apply = cmd_api && ((cmd_frame_type == `MCH_FT_LOCAL_AT)
      || (is_remote && cmd_options[`MCH_REMOTE_APPLY_BIT]));
   // queued frames only stage values; they wait for an apply
   wire do_apply = (go && (cmd_code == MCH_C_APPLY))
      || (go && (cmd_code == MCH_C_EXIT) && cmd_mode)
      || (take && frame_apply)
      || (cmd_mode_timeout && cmd_mode);
   wire rst_fire = (state == MCH_S_RSTWAIT)
      && (rst_cnt == RESET_DELAY_CYCLES[21:0] - 22'd1);
   wire suppress = cmd_api && (cmd_frame_id == 8'h00);
   wire nv_suppress = nv_api && (nv_frame_id == 8'h00);

   // query answers
   logic [15:0] query_value;
   always_comb
   begin
      query_value = 16'h0000;
      case (cmd_code)
         MCH_C_TEMP: query_value = temp_c;
         MCH_C_SUPPLY: query_value = supply_mv;
         MCH_C_POWER: query_value = {15'h0000, power_sync};
         MCH_C_FWVER: query_value = `MCH_FW_VERSION;
         MCH_C_HWVER: query_value = `MCH_HW_VERSION;
         MCH_C_COMPAT: query_value = hw_compat;
         MCH_C_PARAM: query_value = active[cmd_param_sel];
         default: query_value = 16'h0000;
      endcase
   end

   // state machine: a write holds the port until flash finishes
   always_comb
   begin
      next_state = state;
      case (state)
         MCH_S_IDLE:
         begin
            if (do_write)
               next_state = MCH_S_NVWAIT;
            else if (do_restart || do_bootldr)
               next_state = MCH_S_RSTWAIT;
         end
         MCH_S_NVWAIT:
         begin
            if (nv_done)
               next_state = MCH_S_IDLE;
         end
         MCH_S_RSTWAIT:
         begin
            if (rst_fire)
               next_state = MCH_S_IDLE;
         end
         default: next_state = MCH_S_IDLE;
      endcase
   end

   assign cmd_ready = (state == MCH_S_IDLE);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         state <= MCH_S_IDLE;
      else
         state <= next_state;
   end

   // reset delay counter
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_cnt <= 22'd0;
         rst_to_loader <= 1'b0;
      end
      else if (take && (do_restart || do_bootldr))
      begin
         rst_cnt <= 22'd0;
         rst_to_loader <= do_bootldr;
      end
      else if (state == MCH_S_RSTWAIT)
         rst_cnt <= rst_cnt + 22'd1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sys_reset_req <= 1'b0;
         boot_to_loader <= 1'b0;
      end
      else
      begin
         sys_reset_req <= rst_fire;
         boot_to_loader <= rst_fire && rst_to_loader;
      end
   end

   // command mode
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cmd_mode <= 1'b0;
      else if (rst_fire)
         cmd_mode <= 1'b0;
      else if (cmd_mode_timeout || (go && (cmd_code == MCH_C_EXIT)))
         cmd_mode <= 1'b0;
      else if (cmd_mode_enter)
         cmd_mode <= 1'b1;
   end

   // one-shot capture of the next command after set-custom-default
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         custom_next <= 1'b0;
      else if (go && (cmd_code == MCH_C_SETCUST))
         custom_next <= 1'b1;
      else if (take)
         custom_next <= 1'b0;
   end

   // parameter storage, one slice per entry
   genvar gi;
   generate
      for (gi = 0; gi < `MCH_NPARAM; gi = gi + 1)
      begin : g_par
         localparam logic [2:0] IDX = 3'(gi);
         localparam logic [15:0] FACT = (IDX == `MCH_P_BAUD)
            ? `MCH_FACTORY_BAUD : `MCH_FACTORY_OTHER;
         wire hit = do_param && (cmd_param_sel == IDX);
         wire kept = (IDX == `MCH_P_STACK) || (IDX == `MCH_P_COMPAT)
            || (IDX == `MCH_P_KEY);
         wire [15:0] dflt = cust_mask[gi] ? custom[gi] : FACT;
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               pending[gi] <= FACT;
               pend_mask[gi] <= 1'b0;
            end
            else if (hit)
            begin
               pending[gi] <= cmd_value;
               pend_mask[gi] <= 1'b1;
            end
            else if (do_restore && !kept)
            begin
               pending[gi] <= dflt;
               pend_mask[gi] <= 1'b1;
            end
            else if (do_factory)
            begin
               pending[gi] <= FACT;
               pend_mask[gi] <= 1'b1;
            end
            else if (do_apply)
               pend_mask[gi] <= 1'b0;
         end
         // baud and all others switch only here
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               active[gi] <= FACT;
            else if (do_apply && hit)
               active[gi] <= cmd_value;
            else if (do_apply && pend_mask[gi])
               active[gi] <= pending[gi];
         end
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               custom[gi] <= 16'h0000;
               cust_mask[gi] <= 1'b0;
            end
            else if (do_clrcust)
               cust_mask[gi] <= 1'b0;
            else if (hit && custom_next)
            begin
               custom[gi] <= cmd_value;
               cust_mask[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   assign baud_rate_setting = active[`MCH_P_BAUD];

   // flash write bookkeeping
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         nv_write_start <= 1'b0;
         nv_api <= 1'b0;
         nv_frame_id <= 8'h00;
         nv_frame_type <= 8'h00;
      end
      else
      begin
         nv_write_start <= do_write;
         if (do_write)
         begin
            nv_api <= cmd_api;
            nv_frame_id <= cmd_frame_id;
            nv_frame_type <= cmd_frame_type;
         end
      end
   end

   // responses: flash OK waits for nv_done so the host may continue
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         resp_valid <= 1'b0;
         resp_status <= MCH_R_OK;
         resp_value <= 16'h0000;
         resp_frame_id <= 8'h00;
         resp_frame_type <= 8'h00;
      end
      else if ((state == MCH_S_NVWAIT) && nv_done)
      begin
         resp_valid <= !nv_suppress;
         resp_status <= MCH_R_OK;
         resp_value <= 16'h0000;
         resp_frame_id <= nv_frame_id;
         resp_frame_type <= nv_frame_type;
      end
      else if (take && !do_write)
      begin
         resp_valid <= !suppress;
         resp_frame_id <= cmd_frame_id;
         resp_frame_type <= cmd_frame_type;
         if (refused)
         begin
            resp_status <= MCH_R_ERROR;
            resp_value <= 16'h0000;
         end
         else if (is_query || ((cmd_code == MCH_C_PARAM) && !cmd_is_set))
         begin
            resp_status <= MCH_R_VALUE;
            resp_value <= query_value;
         end
         else
         begin
            resp_status <= MCH_R_OK;
            resp_value <= 16'h0000;
         end
      end
      else
         resp_valid <= 1'b0;
   end

   // firmware image gate
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         boot_block <= 1'b0;
         fw_load_accept <= 1'b0;
         fw_load_reject <= 1'b0;
      end
      else
      begin
         fw_load_accept <= fw_load_valid && (fw_compat_num >= hw_compat);
         fw_load_reject <= fw_load_valid && (fw_compat_num < hw_compat);
         if (fw_image_bad)
            boot_block <= 1'b1;
         else if (fw_load_valid && (fw_compat_num >= hw_compat))
            boot_block <= 1'b0;
      end
   end

   assign boot_enable = !boot_block;

   // strap from a pin, two flops before use
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         power_meta <= 1'b0;
         power_sync <= 1'b0;
      end
      else
      begin
         power_meta <= power_variant_pin;
         power_sync <= power_meta;
      end
   end

   // transmit status: the id is held from request to completion
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_busy <= 1'b0;
         tx_id_hold <= 8'h00;
         txs_valid <= 1'b0;
         txs_frame_id <= 8'h00;
         txs_cause <= 8'h00;
      end
      else
      begin
         txs_valid <= 1'b0;
         if (tx_req_valid)
         begin
            tx_busy <= 1'b1;
            tx_id_hold <= tx_req_frame_id;
         end
         else if (tx_done && tx_busy)
         begin
            tx_busy <= 1'b0;
            txs_valid <= (tx_id_hold != 8'h00);
            txs_frame_id <= tx_id_hold;
            txs_cause <= tx_cause;
         end
      end
   end

   // received data and remote response forwarding
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_out_valid <= 1'b0;
         rx_out_type <= `MCH_FT_RX_PLAIN;
         remote_resp_out_valid <= 1'b0;
         remote_resp_out_id <= 8'h00;
      end
      else
      begin
         rx_out_valid <= rx_valid;
         if (rx_valid)
            rx_out_type <= active[`MCH_P_AO][0]
               ? `MCH_FT_RX_EXPLICIT : `MCH_FT_RX_PLAIN;
         remote_resp_out_valid <= remote_resp_valid && remote_delivered
            && (remote_resp_id != 8'h00);
         if (remote_resp_valid)
            remote_resp_out_id <= remote_resp_id;
      end
   end

   // register port
   wire sel_status = (reg_addr == `MCH_REG_STATUS);
   wire sel_compat = (reg_addr == `MCH_REG_HWCOMPAT);
   wire sel_sensor = (reg_addr == `MCH_REG_SENSOR);
   wire sel_baud = (reg_addr == `MCH_REG_BAUD);
   wire [31:0] status_word = {26'h000_0000, (|pend_mask),
      (state == MCH_S_NVWAIT), custom_next, boot_block,
      (state == MCH_S_RSTWAIT), cmd_mode};
   wire [31:0] rd_mux = sel_status ? status_word
      : sel_compat ? {16'h0000, hw_compat}
      : sel_sensor ? {supply_mv, temp_c}
      : sel_baud ? {16'h0000, baud_rate_setting}
      : 32'h0000_0000;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         hw_compat <= `MCH_HW_COMPAT_RST;
      else if (reg_wr && sel_compat)
         hw_compat <= reg_wdata[15:0];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
         reg_rdata <= rd_mux;
      else
         reg_rdata <= 32'h0000_0000;
   end
endmodule
`default_nettype wire

// ### mch_command_handler_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "mch_params.svh"
module mch_command_handler_asserts #(
   parameter int unsigned RESET_DELAY_CYCLES = 20
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire mch_pkg::mch_cmd_t cmd_code,
   input wire logic cmd_api,
   input wire logic [7:0] cmd_frame_type,
   input wire logic [7:0] cmd_frame_id,
   input wire logic cmd_is_set,
   input wire logic resp_valid,
   input wire mch_pkg::mch_resp_t resp_status,
   input wire logic [15:0] resp_value,
   input wire logic nv_write_start,
   input wire logic sys_reset_req,
   input wire logic boot_to_loader,
   input wire logic cmd_mode,
   input wire logic [15:0] temp_c,
   input wire logic [15:0] supply_mv,
   input wire logic tx_done,
   input wire logic txs_valid,
   input wire logic [7:0] txs_frame_id
);
   import mch_pkg::*;
   logic take, rst_take, qry, lcl, armed;
   logic [15:0] qval;
   logic [31:0] cnt;
   assign take = cmd_valid && cmd_ready;
   assign rst_take = take && cmd_code == MCH_C_RESTART;
   assign qry = cmd_code == MCH_C_TEMP || cmd_code == MCH_C_SUPPLY;
   assign qval = (cmd_code == MCH_C_TEMP) ? temp_c : supply_mv;
   assign lcl = cmd_code == MCH_C_SETCUST || cmd_code == MCH_C_CLRCUST
      || cmd_code == MCH_C_BOOTLDR;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         armed <= 1'b0;
      else if (rst_take)
         armed <= 1'b1;
      else if (sys_reset_req)
         armed <= 1'b0;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cnt <= 32'h0000_0000;
      else
         cnt <= rst_take ? 32'h0000_0001 : cnt + 32'h0000_0001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_RESTART_OK:
      assert property (rst_take |=> resp_status == MCH_R_OK && !cmd_ready)
      else $error("restart answer wrong");
   AST_RESET_DELAY:
      assert property (sys_reset_req && !boot_to_loader
         |-> armed && cnt == RESET_DELAY_CYCLES + 1)
      else $error("reset request at wrong time");
   AST_RESET_EXITS:
      assert property (sys_reset_req |=> !cmd_mode)
      else $error("command mode kept over reset");
   AST_QUERY:
      assert property (take && !cmd_is_set && qry
         |=> resp_status == MCH_R_VALUE && resp_value == $past(qval))
      else $error("query value wrong");
   AST_RO_SET:
      assert property (take && cmd_is_set && qry |=> resp_status == MCH_R_ERROR)
      else $error("set on query accepted");
   AST_ID_ZERO:
      assert property (take && cmd_api && cmd_frame_id == 8'h00
         && cmd_code != MCH_C_WRITE |=> !resp_valid)
      else $error("response not suppressed");
   AST_WRITE:
      assert property (take && cmd_code == MCH_C_WRITE
         |=> nv_write_start && !cmd_ready)
      else $error("flash write not started");
   AST_LOCAL_ONLY:
      assert property (take && cmd_api && cmd_frame_type == `MCH_FT_REMOTE_AT
         && lcl |=> resp_status == MCH_R_ERROR ##1 !boot_to_loader[*4])
      else $error("remote local-only command honoured");
   AST_TXS:
      assert property (txs_valid |-> txs_frame_id != 8'h00 && $past(tx_done))
      else $error("transmit status unexpected");
endmodule
bind mch_command_handler mch_command_handler_asserts #(
   .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)
) i_chk (.*);
`default_nettype wire

// ### mch_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module mch_flash_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic nv_write_start,
   input wire logic [7:0] latency,
   output logic nv_done
);
   logic [7:0] left;
   // one write in flight; latency of at least 1
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         left <= 8'h00;
         nv_done <= 1'b0;
      end
      else
      begin
         nv_done <= left == 8'h01;
         if (nv_write_start)
            left <= latency;
         else if (left != 8'h00)
            left <= left - 8'h01;
      end
   end
endmodule
`default_nettype wire

// ### mch_command_handler_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mch_params.svh"
module mch_command_handler_bench;
   import mch_pkg::*;
   localparam int RD = 20;
   logic clk, reset_n, cmd_valid, cmd_ready, cmd_api, cmd_is_set, got;
   logic cmd_mode_enter, cmd_mode_timeout, resp_valid, nv_write_start;
   logic nv_done, sys_reset_req, boot_to_loader, boot_enable, cmd_mode;
   logic fw_load_valid, fw_image_bad, fw_load_accept, fw_load_reject;
   logic power_variant_pin, tx_req_valid, tx_done, txs_valid, rx_valid;
   logic rx_out_valid, remote_resp_valid, remote_delivered, reg_wr, reg_rd;
   logic remote_resp_out_valid;
   logic [7:0] cmd_frame_type, cmd_frame_id, cmd_options, resp_frame_id;
   logic [7:0] resp_frame_type, tx_req_frame_id, tx_cause, txs_frame_id;
   logic [7:0] txs_cause, rx_out_type, remote_resp_id, remote_resp_out_id;
   logic [7:0] lat;
   logic [15:0] cmd_value, resp_value, fw_compat_num, temp_c, supply_mv;
   logic [15:0] baud_rate_setting;
   logic [2:0] cmd_param_sel;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   mch_cmd_t cmd_code;
   mch_resp_t resp_status;
   int err_total = 0;
   int tests_run = 0;
   int seed = 42171;
   int n;
   mch_command_handler #(.RESET_DELAY_CYCLES(RD)) i_dut (.*);
   mch_flash_model i_nv (.clk(clk), .reset_n(reset_n),
      .nv_write_start(nv_write_start), .latency(lat), .nv_done(nv_done));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         err_total++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task report_and_stop;
      $display("mismatches %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmd(input mch_cmd_t c, input logic [7:0] ft = 8'h00,
      input logic [7:0] id = 8'h01, input logic s = 1'b0,
      input logic [2:0] sel = 3'h0, input logic [15:0] v = 16'h0000);
      @(posedge clk);
      cmd_code <= c;
      cmd_api <= ft != 8'h00;
      cmd_frame_type <= ft;
      cmd_frame_id <= id;
      cmd_is_set <= s;
      cmd_param_sel <= sel;
      cmd_value <= v;
      cmd_valid <= 1'b1;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (cmd_ready !== 1'b1 && n < 500);
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      n = 0;
      while (resp_valid !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      got = resp_valid;
      repeat (2) @(negedge clk);
   endtask
   task automatic mode(input logic t);
      @(posedge clk);
      cmd_mode_enter <= !t;
      cmd_mode_timeout <= t;
      @(posedge clk);
      cmd_mode_enter <= 1'b0;
      cmd_mode_timeout <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic rg(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge clk);
      if (!w)
         chk(reg_rdata, d);
   endtask
   initial
   begin
      {cmd_valid, cmd_api, cmd_is_set, cmd_mode_enter, cmd_mode_timeout} = '0;
      {tx_req_valid, tx_done, rx_valid, remote_resp_valid} = '0;
      {remote_delivered, fw_load_valid, fw_image_bad, reg_wr, reg_rd} = '0;
      {cmd_frame_type, cmd_frame_id, cmd_options, tx_req_frame_id} = '0;
      {tx_cause, remote_resp_id, cmd_value, fw_compat_num} = '0;
      {cmd_param_sel, reg_addr, reg_wdata} = '0;
      cmd_code = MCH_C_TEMP;
      temp_c = 16'hffff;
      supply_mv = 16'h0cf0;
      power_variant_pin = 1'b1;
      lat = 8'h01;
      reset_n = 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk(baud_rate_setting, 16'h0003);
      repeat (3)
      begin
         cmd(MCH_C_TEMP, 8'h08);
         chk(resp_value, temp_c);
         cmd(MCH_C_SUPPLY);
         chk(resp_value, supply_mv);
         temp_c <= $random(seed);
         supply_mv <= $random(seed);
      end
      cmd(MCH_C_POWER, 8'h08);
      chk(resp_value, 16'h0001);
      cmd(MCH_C_FWVER, 8'h08);
      chk(resp_value, `MCH_FW_VERSION);
      cmd(MCH_C_TEMP, 8'h08, 8'h01, 1'b1, 3'h0, 16'h1234);
      chk(resp_status, MCH_R_ERROR);
      cmd(MCH_C_SUPPLY, 8'h08, 8'h00);
      chk(got, 1'b0);
      mode(1'b0);
      cmd(MCH_C_PARAM, 8'h00, 8'h01, 1'b1, 3'h0, 16'h0005);
      chk(baud_rate_setting, 16'h0003);
      cmd(MCH_C_APPLY);
      chk(baud_rate_setting, 16'h0005);
      cmd(MCH_C_PARAM, 8'h09, 8'h01, 1'b1, 3'h0, 16'h0006);
      chk(baud_rate_setting, 16'h0005);
      mode(1'b1);
      chk(baud_rate_setting, 16'h0006);
      cmd(MCH_C_PARAM, 8'h17, 8'h01, 1'b1, 3'h0, 16'h0002);
      chk(baud_rate_setting, 16'h0006);
      cmd_options <= 8'h02;
      cmd(MCH_C_PARAM, 8'h17, 8'h01, 1'b1, 3'h0, 16'h0002);
      chk(baud_rate_setting, 16'h0002);
      cmd(MCH_C_PARAM, 8'h08, 8'h01, 1'b1, 3'h0, 16'h0007);
      chk(baud_rate_setting, 16'h0007);
      mode(1'b0);
      cmd(MCH_C_PARAM, 8'h00, 8'h01, 1'b1, 3'h0, 16'h0004);
      cmd(MCH_C_EXIT);
      chk(baud_rate_setting, 16'h0004);
      cmd(MCH_C_SETCUST, 8'h17);
      chk(resp_status, MCH_R_ERROR);
      cmd(MCH_C_SETCUST, 8'h08);
      cmd(MCH_C_PARAM, 8'h08, 8'h01, 1'b1, 3'h0, 16'h0009);
      chk(baud_rate_setting, 16'h0009);
      cmd(MCH_C_PARAM, 8'h08, 8'h01, 1'b1, 3'h0, 16'h0004);
      cmd(MCH_C_RESTORE);
      chk(baud_rate_setting, 16'h0004);
      cmd(MCH_C_APPLY);
      chk(baud_rate_setting, 16'h0009);
      cmd(MCH_C_CLRCUST, 8'h08);
      chk(baud_rate_setting, 16'h0009);
      cmd(MCH_C_RESTORE);
      cmd(MCH_C_APPLY);
      chk(baud_rate_setting, 16'h0003);
      cmd(MCH_C_SETCUST, 8'h08);
      cmd(MCH_C_PARAM, 8'h08, 8'h01, 1'b1, 3'h0, 16'h0009);
      cmd(MCH_C_FACTORY);
      cmd(MCH_C_APPLY);
      chk(baud_rate_setting, 16'h0003);
      for (int i = 0; i < 2; i++)
      begin
         cmd(MCH_C_PARAM, 8'h08, 8'h01, 1'b1, 3'h4, {15'h0000, !i[0]});
         lat <= i ? 8'h0c : 8'h01;
         cmd(MCH_C_WRITE, 8'h08);
         chk(got, 1'b1);
         @(posedge clk);
         rx_valid <= 1'b1;
         tx_req_frame_id <= i ? 8'h00 : 8'h05;
         tx_cause <= 8'h21;
         remote_delivered <= !i[0];
         remote_resp_id <= 8'h03;
         tx_req_valid <= 1'b1;
         remote_resp_valid <= 1'b1;
         @(posedge clk);
         {rx_valid, tx_req_valid, remote_resp_valid} <= '0;
         tx_done <= 1'b1;
         @(negedge clk);
         chk(rx_out_type, i ? 8'h90 : 8'h91);
         chk(remote_resp_out_valid, i == 0);
         @(posedge clk);
         tx_done <= 1'b0;
         @(negedge clk);
         chk(txs_valid, i == 0);
         chk(txs_cause, 8'h21);
      end
      rg(1'b0, 4'h2, {supply_mv, temp_c});
      rg(1'b0, 4'hf, 32'h0000_0000);
      rg(1'b1, 4'h1, 32'h0000_0005);
      rg(1'b0, 4'h1, 32'h0000_0005);
      fw_image_bad <= 1'b1;
      @(posedge clk);
      fw_image_bad <= 1'b0;
      @(negedge clk);
      chk(boot_enable, 1'b0);
      for (int i = 4; i < 6; i++)
      begin
         fw_compat_num <= i[15:0];
         fw_load_valid <= 1'b1;
         @(posedge clk);
         fw_load_valid <= 1'b0;
         @(negedge clk);
         chk({fw_load_reject, fw_load_accept}, i == 4 ? 2'b10 : 2'b01);
      end
      chk(boot_enable, 1'b1);
      cmd(MCH_C_BOOTLDR, 8'h17);
      chk(resp_status, MCH_R_ERROR);
      mode(1'b0);
      cmd(MCH_C_RESTART);
      chk(resp_status, MCH_R_OK);
      n = 2;
      while (sys_reset_req !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      chk(n, RD + 1);
      @(negedge clk);
      chk(cmd_mode, 1'b0);
      cmd(MCH_C_BOOTLDR, 8'h08);
      n = 0;
      while (boot_to_loader !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      chk(boot_to_loader, 1'b1);
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk(baud_rate_setting, 16'h0003);
      report_and_stop;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      report_and_stop;
   end
endmodule
`default_nettype wire
